// ==== region_pkg.sv ====
/*
 Types and constants shared by the region fragment builder, its checker and its bench.
 Assumes one system clock domain and 32-bit output link words.
*/
package region_pkg;

    localparam int WORD_W = 32;
    localparam int LIMIT_W = 16;
    localparam int FIFO_DEPTH = 32;

    // Word tags in the top bits of each payload word.
    localparam logic [1:0] TAG_CLUSTER = 2'h0;
    localparam logic [2:0] TAG_JET = 3'h4;
    localparam logic [2:0] TAG_JET_ET = 3'h5;
    localparam logic [3:0] TAG_EX = 4'h4;
    localparam logic [3:0] TAG_EY = 4'h6;
    localparam logic [3:0] TAG_ET = 4'h5;
    localparam logic [7:0] TRAILER_MARK = 8'hE0;

    // Bit positions inside the common half of both status words.
    localparam int ST_CROSSING = 0;
    localparam int ST_EVENT_NUMBER = 1;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_INTERNAL = 3;
    localparam int ST_TRANSPORT = 4;
    localparam int ST_FIFO = 5;
    // Bit positions inside the private half of status word 1.
    localparam int PV_SERIAL_LINK = 0;
    localparam int PV_CABLE_PARITY = 1;
    localparam int PV_INPUT_LINK = 2;
    // Bit positions inside the private half of status word 2.
    localparam int PV_TRUNCATION = 0;
    localparam int PV_TRIGGER_TIMEOUT = 1;

    typedef enum logic [2:0] {
        ITEM_CLUSTER, ITEM_JET, ITEM_JET_ET, ITEM_ENERGY, ITEM_CLOSE
    } item_kind_t;

    typedef struct packed {
        logic [1:0] crate;
        logic [3:0] module_num;
    } source_id_t;

    typedef struct packed {
        logic crossing_mismatch;
        logic arrival_timeout;
        logic fifo_overflow;
        logic serial_link_error;
        logic input_link_error;
        logic cable_parity_error;
        logic trigger_timeout;
        logic [7:0] trigger_type;
    } close_info_t;

    typedef struct packed {
        item_kind_t kind;
        logic [4:0] line;
        logic [1:0] lc;
        logic [2:0] frame;
        logic fwd;
        logic [7:0] thr_a;
        logic [7:0] thr_b;
        logic sat;
        logic err;
        logic [11:0] bunch_crossing_number;
        logic [14:0] ex;
        logic [14:0] ey;
        logic [14:0] et;
        logic [2:0] ovf;
        logic [3:0] sum_hits;
        logic [7:0] miss_hits;
        close_info_t info;
    } item_t;

    typedef struct packed {
        logic [1:0] tag;
        logic [1:0] crate;
        logic [3:0] module_num;
        logic [2:0] chip;
        logic [1:0] lc;
        logic zero;
        logic err;
        logic sat;
        logic [7:0] thr_hi;
        logic [7:0] thr_lo;
    } cluster_word_t;

    typedef struct packed {
        logic [2:0] tag;
        logic crate;
        logic [3:0] module_num;
        logic [2:0] frame;
        logic [1:0] lc;
        logic fwd;
        logic err;
        logic sat;
        logic [3:0] zero;
        logic [3:0] fwd_thr;
        logic [7:0] main_thr;
    } jet_word_t;

    typedef struct packed {
        logic [2:0] tag;
        logic err;
        logic [23:0] zero;
        logic [3:0] hits;
    } jet_et_word_t;

    typedef struct packed {
        logic [3:0] tag;
        logic err;
        logic [10:0] zero;
        logic ovf;
        logic [14:0] value;
    } energy_x_word_t;

    typedef struct packed {
        logic [3:0] tag;
        logic err;
        logic [6:0] zero;
        logic [3:0] hits;
        logic ovf;
        logic [14:0] value;
    } energy_y_word_t;

    typedef struct packed {
        logic [3:0] tag;
        logic err;
        logic [2:0] zero;
        logic [7:0] hits;
        logic ovf;
        logic [14:0] value;
    } energy_t_word_t;

    typedef struct packed {
        logic [15:0] private_bits;
        logic [15:0] common;
    } status_word_t;

    typedef struct packed {
        logic [7:0] marker;
        logic [23:0] count;
    } trailer_word_t;

    typedef struct packed {
        logic last;
        logic [WORD_W-1:0] data;
    } out_word_t;

endpackage : region_pkg

// ==== word_fifo.sv ====
/*
 Synchronous FIFO with a registered read stage.
 Assumes DEPTH is a power of two and a single clock.
*/
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
    logic [AW:0] count, next_count;
    logic next_rd_valid;
    logic [WIDTH-1:0] next_rd_data;
    logic push, pop;

    assign wr_ready = (count != (AW+1)'(DEPTH));

    always_comb
    begin
        push = wr_valid && wr_ready;
        pop = (count != '0) && (!rd_valid || rd_ready);
        next_wptr = push ? AW'(wptr + 1'b1) : wptr;
        next_rptr = pop ? AW'(rptr + 1'b1) : rptr;
        next_count = count;
        if (push && !pop)
            next_count = (AW+1)'(count + 1'b1);
        else if (pop && !push)
            next_count = (AW+1)'(count - 1'b1);
        next_rd_valid = pop || (rd_valid && !rd_ready);
        next_rd_data = pop ? mem[rptr] : rd_data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            rd_valid <= 1'b0;
            rd_data <= '0;
        end
        else
        begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wptr] <= wr_data;
    end

endmodule : word_fifo

// ==== region_fragment_builder.sv ====
/*
 Region fragment builder: formats decoded input items into payload words,
 suppresses empty words, enforces the payload word limit and closes each
 fragment with two status words and a trailer through an output FIFO.
 Assumes items of one event arrive in order and end with a close item.
*/
`timescale 1ns/1ps
// Summary of operation
// - Payload is flat; every addressed word carries crate, module, chip (frame in jet words), place.
// - Payload words of each fragment are counted against the programmed limit.
// - At the limit, later words are dropped and truncation flagged until the close item.
// - Cluster word: two maps, error, saturation; coordinates from line number and item lc bit 0.
// - Cluster module and crate numbers come from the source identifier.
// - Cluster word dropped when maps, saturation and error are all zero.
// - Jet word copies thresholds, saturation, location, frame, parity error, source.
// - Jet word dropped when twelve thresholds, saturation, parity error are zero.
// - Merger items are checked for crossing number before their fields are used.
// - One unaddressed jet energy word carries four hits and parity error.
// - Jet energy word dropped when hits and parity error are zero.
// - Energy region gives three unaddressed words: X, Y with sums, total.
// - The three energy words are never suppressed as empty; only the payload limit drops them.
// - Two status words precede the trailer; one means failure.
// - Event number mismatch and internal transfer error bits are always zero.
// - Status word 1 flags mismatch, timeout, overflow, link errors, and parity errors if the event had a merger item.
// - Transport error summary is the OR of the private bits of word 1.
// - Status word 2 has truncation and trigger timeout; timeout forces type zero.
module region_fragment_builder
    import region_pkg::*;
#(
    parameter int LIMIT_BITS = region_pkg::LIMIT_W,
    parameter int DEPTH = region_pkg::FIFO_DEPTH
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire region_pkg::item_t IN_ITEM,
    input wire region_pkg::source_id_t SOURCE_ID,
    input wire logic [11:0] EXPECTED_BCN,
    input wire logic [LIMIT_BITS-1:0] PAYLOAD_WORD_LIMIT,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [region_pkg::WORD_W-1:0] OUT_DATA,
    output logic OUT_LAST,
    output logic [7:0] TRIGGER_TYPE,
    output logic TRUNCATED
);
    import region_pkg::*;

    typedef enum {
        S_IDLE, S_WORD, S_EN_X, S_EN_Y, S_EN_T, S_STAT1, S_STAT2, S_TRAIL
    } state_t;

    state_t state, next_state;
    item_t item, next_item;
    logic [LIMIT_BITS-1:0] count, next_count;
    logic trunc, next_trunc;
    logic bcn_err, next_bcn_err;
    logic merger_seen, next_merger_seen;
    logic in_ready, next_in_ready;
    logic [7:0] trig_type, next_trig_type;
    logic truncated, next_truncated;

    logic wr_valid, wr_ready, keep, payload, at_limit;
    out_word_t wr_word, rd_word;
    cluster_word_t cw;
    jet_word_t jw;
    jet_et_word_t ew;
    energy_x_word_t xw;
    energy_y_word_t yw;
    energy_t_word_t tw;
    status_word_t s1, s2;
    trailer_word_t tr;

    assign IN_READY = in_ready;
    assign OUT_DATA = rd_word.data;
    assign OUT_LAST = rd_word.last;
    assign TRIGGER_TYPE = trig_type;
    assign TRUNCATED = truncated;

    // Word images for the item held in the working register.
    always_comb
    begin
        cw = '0;
        cw.tag = TAG_CLUSTER;
        cw.crate = SOURCE_ID.crate;
        cw.module_num = SOURCE_ID.module_num;
        cw.chip = item.line[3:1];
        cw.lc = {item.line[0], item.lc[0]};
        cw.err = item.err;
        cw.sat = item.sat;
        cw.thr_hi = item.thr_a;
        cw.thr_lo = item.thr_b;
        jw = '0;
        jw.tag = TAG_JET;
        jw.crate = SOURCE_ID.crate[0];
        jw.module_num = SOURCE_ID.module_num;
        jw.frame = item.frame;
        jw.lc = item.lc;
        jw.fwd = item.fwd;
        jw.err = item.err;
        jw.sat = item.sat;
        jw.fwd_thr = item.thr_b[3:0];
        jw.main_thr = item.thr_a;
        ew = '0;
        ew.tag = TAG_JET_ET;
        ew.err = item.err;
        ew.hits = item.thr_a[3:0];
        xw = '0;
        xw.tag = TAG_EX;
        xw.err = item.err;
        xw.ovf = item.ovf[2];
        xw.value = item.ex;
        yw = '0;
        yw.tag = TAG_EY;
        yw.err = item.err;
        yw.hits = item.sum_hits;
        yw.ovf = item.ovf[1];
        yw.value = item.ey;
        tw = '0;
        tw.tag = TAG_ET;
        tw.err = item.err;
        tw.hits = item.miss_hits;
        tw.ovf = item.ovf[0];
        tw.value = item.et;
    end

    // Closing words built from the close item and the event's own findings.
    always_comb
    begin
        s1 = '0;
        s1.common[ST_CROSSING] = bcn_err || item.info.crossing_mismatch;
        s1.common[ST_EVENT_NUMBER] = 1'b0;
        s1.common[ST_INTERNAL] = 1'b0;
        s1.common[ST_TIMEOUT] = item.info.arrival_timeout;
        s1.common[ST_FIFO] = item.info.fifo_overflow;
        s1.private_bits[PV_SERIAL_LINK] = item.info.serial_link_error;
        s1.private_bits[PV_INPUT_LINK] = item.info.input_link_error;
        s1.private_bits[PV_CABLE_PARITY] =
            item.info.cable_parity_error && merger_seen;
        s1.common[ST_TRANSPORT] = |s1.private_bits;
        s2 = '0;
        s2.private_bits[PV_TRUNCATION] = trunc;
        s2.private_bits[PV_TRIGGER_TIMEOUT] = item.info.trigger_timeout;
        tr.marker = TRAILER_MARK;
        tr.count = 24'(count);
    end

    // Sequencer: one word per state except S_IDLE, stalled while the FIFO is full.
    always_comb
    begin
        next_state = state;
        next_item = item;
        next_count = count;
        next_trunc = trunc;
        next_bcn_err = bcn_err;
        next_merger_seen = merger_seen;
        next_trig_type = trig_type;
        next_truncated = truncated;
        keep = 1'b0;
        payload = 1'b0;
        wr_word = '0;
        at_limit = (count >= PAYLOAD_WORD_LIMIT);
        case (state)
            S_IDLE:
            begin
                if (IN_VALID && in_ready)
                begin
                    next_item = IN_ITEM;
                    if (IN_ITEM.kind == ITEM_JET_ET ||
                        IN_ITEM.kind == ITEM_ENERGY)
                    begin
                        next_merger_seen = 1'b1;
                        if (IN_ITEM.bunch_crossing_number != EXPECTED_BCN)
                            next_bcn_err = 1'b1;
                    end
                    if (IN_ITEM.kind == ITEM_CLOSE)
                    begin
                        next_state = S_STAT1;
                        next_trig_type = IN_ITEM.info.trigger_timeout ?
                            8'h00 : IN_ITEM.info.trigger_type;
                    end
                    else if (IN_ITEM.kind == ITEM_ENERGY)
                        next_state = S_EN_X;
                    else
                        next_state = S_WORD;
                end
            end
            S_WORD:
            begin
                payload = 1'b1;
                case (item.kind)
                    ITEM_CLUSTER:
                    begin
                        wr_word.data = cw;
                        keep = |{item.thr_a, item.thr_b, item.sat,
                            item.err};
                    end
                    ITEM_JET:
                    begin
                        wr_word.data = jw;
                        keep = |{item.thr_a, item.thr_b[3:0], item.sat,
                            item.err};
                    end
                    default:
                    begin
                        wr_word.data = ew;
                        keep = |{item.thr_a[3:0], item.err};
                    end
                endcase
            end
            S_EN_X:
            begin
                payload = 1'b1;
                keep = 1'b1;
                wr_word.data = xw;
            end
            S_EN_Y:
            begin
                payload = 1'b1;
                keep = 1'b1;
                wr_word.data = yw;
            end
            S_EN_T:
            begin
                payload = 1'b1;
                keep = 1'b1;
                wr_word.data = tw;
            end
            S_STAT1:
            begin
                keep = 1'b1;
                wr_word.data = s1;
            end
            S_STAT2:
            begin
                keep = 1'b1;
                wr_word.data = s2;
            end
            S_TRAIL:
            begin
                keep = 1'b1;
                wr_word.data = tr;
                wr_word.last = 1'b1;
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase

        // Payload beyond the limit is dropped and the event marked truncated.
        if (payload && keep && at_limit)
        begin
            keep = 1'b0;
            next_trunc = 1'b1;
        end
        wr_valid = keep;

        if (!keep || wr_ready)
        begin
            if (payload && keep)
                next_count = LIMIT_BITS'(count + 1'b1);
            case (state)
                S_WORD: next_state = S_IDLE;
                S_EN_X: next_state = S_EN_Y;
                S_EN_Y: next_state = S_EN_T;
                S_EN_T: next_state = S_IDLE;
                S_STAT1: next_state = S_STAT2;
                S_STAT2: next_state = S_TRAIL;
                S_TRAIL:
                begin
                    next_state = S_IDLE;
                    next_truncated = trunc;
                    next_count = '0;
                    next_trunc = 1'b0;
                    next_bcn_err = 1'b0;
                    next_merger_seen = 1'b0;
                end
                default: next_state = next_state;
            endcase
        end
        next_in_ready = (next_state == S_IDLE);
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= S_IDLE;
            item <= '0;
            count <= '0;
            trunc <= 1'b0;
            bcn_err <= 1'b0;
            merger_seen <= 1'b0;
            in_ready <= 1'b0;
            trig_type <= '0;
            truncated <= 1'b0;
        end
        else
        begin
            state <= next_state;
            item <= next_item;
            count <= next_count;
            trunc <= next_trunc;
            bcn_err <= next_bcn_err;
            merger_seen <= next_merger_seen;
            in_ready <= next_in_ready;
            trig_type <= next_trig_type;
            truncated <= next_truncated;
        end
    end

    word_fifo #(
        .WIDTH($bits(out_word_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst(RST),
        .wr_valid(wr_valid),
        .wr_ready(wr_ready),
        .wr_data(wr_word),
        .rd_valid(OUT_VALID),
        .rd_ready(OUT_READY),
        .rd_data(rd_word)
    );

endmodule : region_fragment_builder

// ==== region_props.sv ====
/*
 Port checker for the region fragment builder.
 Assumes it is bound to the builder and sees only its top-level ports.
*/
`timescale 1ns/1ps
module region_props
    import region_pkg::*;
#(
    parameter int LIMIT_BITS = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic IN_VALID,
    input wire logic IN_READY,
    input wire region_pkg::item_t IN_ITEM,
    input wire logic [LIMIT_BITS-1:0] PAYLOAD_WORD_LIMIT,
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic [region_pkg::WORD_W-1:0] OUT_DATA,
    input wire logic OUT_LAST,
    input wire logic [7:0] TRIGGER_TYPE
);
    logic take;
    logic [31:0] prev1;
    logic [31:0] prev2;
    logic [31:0] next_prev1;
    logic [31:0] next_prev2;
    assign take = OUT_VALID && OUT_READY;
    // Keeps the last two words taken, which are the status words at a trailer.
    always_comb
    begin
        next_prev1 = take ? OUT_DATA : prev1;
        next_prev2 = take ? prev1 : prev2;
    end
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            prev1 <= 32'h0;
            prev2 <= 32'h0;
        end
        else
        begin
            prev1 <= next_prev1;
            prev2 <= next_prev2;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence close_taken;
        IN_VALID && IN_READY && IN_ITEM.kind == ITEM_CLOSE;
    endsequence
    sequence trailer_taken;
        take && OUT_LAST;
    endsequence
    property type_update;
        logic [7:0] t;
        (close_taken, t = IN_ITEM.info.trigger_timeout ? 8'h00 :
            IN_ITEM.info.trigger_type) |=> TRIGGER_TYPE == t;
    endproperty
    out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID &&
        $stable(OUT_DATA) && $stable(OUT_LAST)) else $error("output moved");
    ready_drop_a: assert property (IN_VALID && IN_READY |=> !IN_READY)
        else $error("ready held after take");
    trailer_mark_a: assert property (
        OUT_VALID && OUT_LAST |-> OUT_DATA[31:24] == TRAILER_MARK)
        else $error("last word is no trailer");
    fixed_zero_a: assert property (
        trailer_taken |-> !prev2[1] && !prev2[3] && !prev1[1] && !prev1[3])
        else $error("fixed status bits set");
    transport_or_a: assert property (
        trailer_taken |-> prev2[4] == |prev2[18:16])
        else $error("transport summary wrong");
    word_limit_a: assert property (
        trailer_taken |-> OUT_DATA[23:0] <= 24'(PAYLOAD_WORD_LIMIT))
        else $error("payload above limit");
    truncate_full_a: assert property (
        trailer_taken and prev1[16] |->
        OUT_DATA[23:0] == 24'(PAYLOAD_WORD_LIMIT))
        else $error("truncated below limit");
    type_update_a: assert property (type_update)
        else $error("trigger type wrong");
    type_steady_a: assert property (!(IN_VALID && IN_READY &&
        IN_ITEM.kind == ITEM_CLOSE) |=> $stable(TRIGGER_TYPE))
        else $error("trigger type moved");
    jet_nonzero_a: assert property (
        OUT_VALID && OUT_DATA[31:29] == TAG_JET |->
        |{OUT_DATA[17:16], OUT_DATA[11:0]}) else $error("empty jet word");
    jet_et_nonzero_a: assert property (
        OUT_VALID && OUT_DATA[31:29] == TAG_JET_ET |->
        OUT_DATA[28] || |OUT_DATA[3:0]) else $error("empty jet energy word");
endmodule : region_props

bind region_fragment_builder region_props #(.LIMIT_BITS(LIMIT_BITS))
    region_props_inst (.SYS_CLK(SYS_CLK), .RST(RST), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .IN_ITEM(IN_ITEM),
    .PAYLOAD_WORD_LIMIT(PAYLOAD_WORD_LIMIT), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST),
    .TRIGGER_TYPE(TRIGGER_TYPE));

// ==== level2_sink.sv ====
/*
 Receiving region builder on the output link: takes words, prompt or slow.
 Assumes the bench holds it stalled or slow through its two inputs.
*/
`timescale 1ns/1ps
module level2_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic valid,
    input wire logic stall,
    input wire logic slow,
    output logic ready,
    output logic take
);
    logic next_ready;
    assign take = valid && ready;
    // Slow mode accepts on every other cycle only.
    always_comb
    begin
        next_ready = !stall && (!slow || !ready);
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ready <= 1'b0;
        else
            ready <= next_ready;
    end
endmodule : level2_sink

// ==== test_region_fragment_builder.sv ====
/*
 Self-checking bench for the region fragment builder.
 Assumes the sink model and the port checker are compiled alongside.
*/
`timescale 1ns/1ps
module test_region_fragment_builder;
    import region_pkg::*;
    logic sys_clk, rst, in_valid, in_ready, out_valid, out_ready, out_last;
    logic truncated, stall, slow, take;
    item_t in_item, it;
    source_id_t sid;
    logic [11:0] exp_bcn;
    logic [15:0] limit;
    logic [31:0] out_data;
    logic [7:0] trig_type;
    logic [64:0] exp_q[$];
    int mismatches, num_checks, cycles;

    region_fragment_builder region_fragment_builder_inst (.SYS_CLK(sys_clk),
        .RST(rst), .IN_VALID(in_valid), .IN_READY(in_ready),
        .IN_ITEM(in_item), .SOURCE_ID(sid), .EXPECTED_BCN(exp_bcn),
        .PAYLOAD_WORD_LIMIT(limit), .OUT_VALID(out_valid),
        .OUT_READY(out_ready), .OUT_DATA(out_data), .OUT_LAST(out_last),
        .TRIGGER_TYPE(trig_type), .TRUNCATED(truncated));
    level2_sink level2_sink_inst (.clk(sys_clk), .rst(rst),
        .valid(out_valid), .stall(stall), .slow(slow), .ready(out_ready),
        .take(take));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic put(input item_t i);
        @(posedge sys_clk);
        in_item <= i;
        in_valid <= 1'b1;
        do @(posedge sys_clk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
    endtask : put

    task automatic want(input logic [31:0] d, input logic [31:0] m,
        input logic l);
        exp_q.push_back({l, m, d});
    endtask : want

    task automatic want_close(input logic [31:0] s1, input logic [31:0] s2,
        input int n);
        want(s1, 32'hFFFFFFFF, 1'b0);
        want(s2, 32'hFFFFFFFF, 1'b0);
        want({TRAILER_MARK, 24'(n)}, 32'hFFFFFFFF, 1'b1);
    endtask : want_close

    task automatic drain;
        while (exp_q.size() != 0)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask : drain

    function automatic item_t mk(input item_kind_t k, input logic [4:0] ln,
        input logic [7:0] a, input logic [7:0] b, input logic e);
        item_t i;
        i = '0;
        i.kind = k;
        i.line = ln;
        i.thr_a = a;
        i.thr_b = b;
        i.err = e;
        i.lc = 2'h1;
        i.frame = 3'h5;
        i.bunch_crossing_number = 12'h123;
        return i;
    endfunction : mk

    function automatic item_t cl(input close_info_t f);
        item_t i;
        i = mk(ITEM_CLOSE, 5'h0, 8'h00, 8'h00, 1'b0);
        i.info = f;
        return i;
    endfunction : cl

    function automatic logic [31:0] cw(input item_t i);
        return {TAG_CLUSTER, sid.crate, sid.module_num, i.line[3:1],
            i.line[0], i.lc[0], 1'b0, i.err, i.sat, i.thr_a, i.thr_b};
    endfunction : cw

    always @(posedge sys_clk)
    begin
        logic [64:0] e;
        e = {~out_last, 32'hFFFFFFFF, ~out_data};
        if (take === 1'b1)
        begin
            if (exp_q.size() != 0)
                e = exp_q.pop_front();
            check_word(out_data & e[63:32], e[31:0] & e[63:32]);
            check_word({31'h0, out_last}, {31'h0, e[64]});
        end
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    initial
    begin
        rst = 1'b1;
        in_valid = 1'b0;
        in_item = '0;
        sid = {2'h2, 4'hB};
        exp_bcn = 12'h123;
        limit = 16'h0010;
        stall = 1'b0;
        slow = 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        it = mk(ITEM_CLUSTER, 5'h05, 8'hA5, 8'h3C, 1'b0);
        want(cw(it), 32'hFFFFFFFF, 1'b0);
        put(it);
        put(mk(ITEM_CLUSTER, 5'h06, 8'h00, 8'h00, 1'b0));
        it = mk(ITEM_JET, 5'h00, 8'h81, 8'h00, 1'b1);
        want({TAG_JET, sid.crate[0], sid.module_num, 3'h5, 2'h1, 1'b0, 1'b1,
            1'b0, 8'h00, 8'h81}, 32'hFFFFFFFF, 1'b0);
        put(it);
        put(mk(ITEM_JET, 5'h01, 8'h00, 8'h00, 1'b0));
        want({TAG_JET_ET, 1'b1, 24'h0, 4'h6}, 32'hFFFFFFFF, 1'b0);
        put(mk(ITEM_JET_ET, 5'h10, 8'h06, 8'h00, 1'b1));
        put(mk(ITEM_JET_ET, 5'h10, 8'h00, 8'h00, 1'b0));
        it = mk(ITEM_ENERGY, 5'h12, 8'h00, 8'h00, 1'b0);
        it.ex = 15'h1234;
        it.ey = 15'h0ABC;
        it.et = 15'h7001;
        it.sum_hits = 4'h9;
        it.miss_hits = 8'hC3;
        want({TAG_EX, 12'h0, 1'b0, it.ex}, 32'hFFFFFFFF, 1'b0);
        want({TAG_EY, 8'h0, 4'h9, 1'b0, it.ey}, 32'hFFFFFFFF, 1'b0);
        want({TAG_ET, 4'h0, 8'hC3, 1'b0, it.et}, 32'hFFFFFFFF, 1'b0);
        put(it);
        want_close(32'h0, 32'h0, 6);
        put(cl(15'h005A));
        drain();
        check_word({24'h0, trig_type}, 32'h5A);
        slow <= 1'b0;
        want_close(32'h00050035, 32'h00020000, 0);
        put(cl(15'h7F33));
        drain();
        check_word({24'h0, trig_type}, 32'h0);
        limit <= 16'h0002;
        for (int i = 0; i < 3; i++)
        begin
            it = mk(ITEM_CLUSTER, 5'(i), 8'h11, 8'h00, 1'b0);
            if (i < 2)
                want(cw(it), 32'hFFFFFFFF, 1'b0);
            put(it);
        end
        put(mk(ITEM_ENERGY, 5'h12, 8'h00, 8'h00, 1'b0));
        want_close(32'h0, 32'h00010000, 2);
        put(cl(15'h0001));
        drain();
        check_word({31'h0, truncated}, 32'h1);
        limit <= 16'h0010;
        it = mk(ITEM_ENERGY, 5'h12, 8'h00, 8'h00, 1'b1);
        it.bunch_crossing_number = 12'h456;
        it.ovf = 3'h5;
        want(32'h48008000, 32'hFFFFFFFF, 1'b0);
        want(32'h68000000, 32'hFFFFFFFF, 1'b0);
        want(32'h58008000, 32'hFFFFFFFF, 1'b0);
        put(it);
        want_close(32'h00020011, 32'h0, 3);
        put(cl(15'h0200));
        drain();
        check_word({31'h0, truncated}, 32'h0);
        limit <= 16'h0040;
        stall <= 1'b1;
        fork
        begin
            repeat (200) @(posedge sys_clk);
            check_word({31'h0, in_ready}, 32'h0);
            stall <= 1'b0;
        end
        join_none
        for (int i = 0; i < 40; i++)
        begin
            it = mk(ITEM_CLUSTER, 5'(i % 16), 8'(i + 1), 8'h00, 1'b0);
            want(cw(it), 32'hFFFFFFFF, 1'b0);
            put(it);
        end
        want_close(32'h0, 32'h0, 40);
        put(cl(15'h0077));
        drain();
        wrap_up();
    end
endmodule : test_region_fragment_builder
